// ==== core/gfm_mux.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - 48 pins, no peripheral function attached after reset except the near-field function on the antenna pins.
// - A function reaches a pin only once routed and connected.
// - Analog selection refused on the 38 pins without analog capability.
// - Crystal pins stay ordinary pins until the crystal enable is set.
// - Antenna pins start on the near-field function, freed when cleared.
// - Unconfigured pin: input and output buffers both off.
// - Standard drive by default, high drive selectable per pin.
// - Output pins choose push-pull or open-drain.
// - Input pins choose floating, pull-up or pull-down.
// - Input edges raise sticky flags, pulse events and wake interrupt.
// - Event channels set, clear or toggle an output without software.
// - An analog pin joins at most one converter or comparator.
// - Standard and low-power comparator never enabled together.
// - Low-power negative input: analog pin zero/one or n/16 supply.
// - Each modulator channel is routed to at most one pin.
// - Trace enable puts trace clock and four data bits on pins.
// - Digital functions go to any pin not already occupied.
module gfm_mux
  import gfm_pkg::*;
(
  // APB slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pads
  input  wire logic [NPIN-1:0]      pad_in,
  output gfm_pad_t  [NPIN-1:0]      pad_o,
  // Peripheral side
  input  wire logic [NPWM-1:0]      pwm_out,
  input  wire logic [NAUX-1:0]      aux_out,
  output logic      [NIFN-1:0]      periph_in,
  input  wire logic                 trace_clk,
  input  wire logic [3:0]           trace_data,
  input  wire logic [NEVT-1:0]      evt_task,
  output logic      [NPIN-1:0]      pin_event,
  // Special and analog connections
  output logic                      xtal_connect,
  output logic                      nfc_connect,
  output logic      [NANA-1:0]      conv_connect,
  output logic      [NANA-1:0]      comp_connect,
  output logic      [NANA-1:0]      lpc_connect,
  output logic                      comp_enable,
  output logic                      lpc_enable,
  output logic      [1:0]           lpc_ref_pin,
  output logic      [3:0]           lpc_ref_frac,
  // Interrupt
  output logic                      irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic     [4:0]      ctrl_ff,  nxt_ctrl;
  logic     [5:0]      lpref_ff, nxt_lpref;
  logic     [NPIN-1:0] out_ff,   nxt_out;
  logic     [NPIN-1:0] stat_ff,  nxt_stat;
  logic     [NPIN-1:0] mask_ff,  nxt_mask;
  gfm_cnf_t            cnf_ff   [NPIN];
  gfm_cnf_t            nxt_cnf  [NPIN];
  logic     [7:0]      osel_ff  [NOFN];
  logic     [7:0]      nxt_osel [NOFN];
  logic     [7:0]      isel_ff  [NIFN];
  logic     [7:0]      nxt_isel [NIFN];
  logic     [9:0]      evt_ff   [NEVT];
  logic     [9:0]      nxt_evt  [NEVT];
  logic     [NPIN-1:0] sync1_ff, sync2_ff, prev_ff;
  logic     [NPIN-1:0] edge_hit, nxt_pev;
  logic     [NIFN-1:0] nxt_pin;
  logic     [NOFN-1:0] fn_val;
  logic                wr_en;
  logic                mapped;
  logic     [31:0]     rd_word;

  assign fn_val = {aux_out, pwm_out};

  // Half of a 48-bit pin vector as a bus word
  function automatic logic [31:0] half(input logic [NPIN-1:0] v,
                                       input logic            hi);
    half = hi ? {16'h0000, v[NPIN-1:32]} : v[31:0];
  endfunction

  // Index of a word inside a register array, or -1 when outside
  function automatic int slot(input logic [11:0] a,
                              input logic [11:0] base,
                              input int          n);
    int k;
    k    = (int'(a) - int'(base)) / 4;
    slot = (a >= base && a[1:0] == 2'b00 && k < n) ? k : -1;
  endfunction

  // ------------------------------------------------------------------
  // APB decode and read mux
  // ------------------------------------------------------------------
  always_comb begin
    int k;
    k       = 0;
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      A_CTRL:    rd_word = {27'h000_0000, ctrl_ff};
      A_LPREF:   rd_word = {26'h000_0000, lpref_ff};
      A_OUT_LO:  rd_word = half(out_ff, 1'b0);
      A_OUT_HI:  rd_word = half(out_ff, 1'b1);
      A_IN_LO:   rd_word = half(sync2_ff, 1'b0);
      A_IN_HI:   rd_word = half(sync2_ff, 1'b1);
      A_STAT_LO: rd_word = half(stat_ff, 1'b0);
      A_STAT_HI: rd_word = half(stat_ff, 1'b1);
      A_MASK_LO: rd_word = half(mask_ff, 1'b0);
      A_MASK_HI: rd_word = half(mask_ff, 1'b1);
      default: begin
        mapped = 1'b0;
        k = slot(paddr, A_EVT, NEVT);
        if (k >= 0) begin
          mapped  = 1'b1;
          rd_word = {22'h00_0000, evt_ff[k]};
        end
        k = slot(paddr, A_CNF, NPIN);
        if (k >= 0) begin
          mapped  = 1'b1;
          rd_word = {22'h00_0000, cnf_ff[k]};
        end
        k = slot(paddr, A_OSEL, NOFN);
        if (k >= 0) begin
          mapped  = 1'b1;
          rd_word = {24'h00_0000, osel_ff[k]};
        end
        k = slot(paddr, A_ISEL, NIFN);
        if (k >= 0) begin
          mapped  = 1'b1;
          rd_word = {24'h00_0000, isel_ff[k]};
        end
      end
    endcase
  end

  // Zero-wait slave, error on unmapped words
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = (psel & penable & ~pwrite & mapped) ? rd_word
                                                       : 32'h0000_0000;
  assign wr_en   = psel & penable & pwrite & mapped;

  // ------------------------------------------------------------------
  // Register file next state
  // ------------------------------------------------------------------
  always_comb begin
    int       k;
    logic [5:0] ep;
    k         = 0;
    ep        = 6'h00;
    nxt_ctrl  = ctrl_ff;
    nxt_lpref = lpref_ff;
    nxt_out   = out_ff;
    nxt_mask  = mask_ff;
    nxt_cnf   = cnf_ff;
    nxt_osel  = osel_ff;
    nxt_isel  = isel_ff;
    nxt_evt   = evt_ff;
    // Sticky edge flags, an edge wins over a clear
    nxt_stat  = stat_ff;
    if (wr_en && paddr == A_STAT_LO) begin
      nxt_stat[31:0] = stat_ff[31:0] & ~pwdata;
    end
    if (wr_en && paddr == A_STAT_HI) begin
      nxt_stat[NPIN-1:32] = stat_ff[NPIN-1:32] & ~pwdata[15:0];
    end
    nxt_stat = nxt_stat | edge_hit;
    if (wr_en) begin
      unique case (paddr)
        A_CTRL: begin
          nxt_ctrl = pwdata[4:0];
          if (pwdata[CTRL_COMP] && pwdata[CTRL_LPC]) begin
            nxt_ctrl[CTRL_LPC] = 1'b0;
          end
        end
        A_LPREF: begin
          if (pwdata[LPREF_USEPIN] || pwdata[3:0] != 4'h0) begin
            nxt_lpref = pwdata[5:0];
          end
        end
        A_OUT_LO:  nxt_out[31:0]      = pwdata;
        A_OUT_HI:  nxt_out[NPIN-1:32] = pwdata[15:0];
        A_MASK_LO: nxt_mask[31:0]     = pwdata;
        A_MASK_HI: nxt_mask[NPIN-1:32] = pwdata[15:0];
        default: begin
          k = slot(paddr, A_EVT, NEVT);
          if (k >= 0) begin
            nxt_evt[k] = pwdata[9:0];
          end
          k = slot(paddr, A_CNF, NPIN);
          if (k >= 0) begin
            nxt_cnf[k] = gfm_cnf_t'(pwdata[CNF_W-1:0]);
            if (ana_slot(6'(k)) == 4'(NANA)) begin
              nxt_cnf[k].ana = ANA_NONE;
            end
          end
          k = slot(paddr, A_OSEL, NOFN);
          if (k >= 0) begin
            nxt_osel[k] = pwdata[7:0];
          end
          k = slot(paddr, A_ISEL, NIFN);
          if (k >= 0) begin
            nxt_isel[k] = pwdata[7:0];
          end
        end
      endcase
    end
    for (int c = 0; c < NEVT; c++) begin
      ep = evt_ff[c][5:0];
      if (evt_task[c] && ep < 6'(NPIN)) begin
        unique case (gfm_act_t'(evt_ff[c][EVT_ACT+1:EVT_ACT]))
          ACT_SET:  nxt_out[ep] = 1'b1;
          ACT_CLR:  nxt_out[ep] = 1'b0;
          ACT_TGL:  nxt_out[ep] = ~nxt_out[ep];
          ACT_NONE: nxt_out[ep] = nxt_out[ep];
        endcase
      end
    end
  end

  // reset returns every setting to default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= CTRL_RST;
      lpref_ff <= LPREF_RST;
      out_ff   <= '0;
      stat_ff  <= '0;
      mask_ff  <= '0;
      cnf_ff   <= '{default: '0};
      osel_ff  <= '{default: 8'h00};
      isel_ff  <= '{default: 8'h00};
      evt_ff   <= '{default: 10'h000};
    end else begin
      ctrl_ff  <= nxt_ctrl;
      lpref_ff <= nxt_lpref;
      out_ff   <= nxt_out;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      cnf_ff   <= nxt_cnf;
      osel_ff  <= nxt_osel;
      isel_ff  <= nxt_isel;
      evt_ff   <= nxt_evt;
    end
  end

  // ------------------------------------------------------------------
  // Input synchronisers, edges and peripheral inputs
  // ------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      edge_hit[p] = pad_o[p].ie &
                    ((cnf_ff[p].sense[0] & sync2_ff[p] & ~prev_ff[p]) |
                     (cnf_ff[p].sense[1] & ~sync2_ff[p] & prev_ff[p]));
    end
    nxt_pev = edge_hit;
    for (int f = 0; f < NIFN; f++) begin
      nxt_pin[f] = isel_ff[f][SEL_CONN] && isel_ff[f][5:0] < 6'(NPIN) &&
                   sync2_ff[isel_ff[f][5:0]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff  <= '0;
      sync2_ff  <= '0;
      prev_ff   <= '0;
      pin_event <= '0;
      periph_in <= '0;
    end else begin
      sync1_ff  <= pad_in;
      sync2_ff  <= sync1_ff;
      prev_ff   <= sync2_ff;
      pin_event <= nxt_pev;
      periph_in <= nxt_pin;
    end
  end

  // Level interrupt, also the wake request
  assign irq = |(stat_ff & mask_ff);

  // ------------------------------------------------------------------
  // Special and analog connections
  // ------------------------------------------------------------------
  // crystal only when enabled
  assign xtal_connect = ctrl_ff[CTRL_XTAL];
  assign nfc_connect  = ctrl_ff[CTRL_NFC];
  assign comp_enable  = ctrl_ff[CTRL_COMP];
  assign lpc_enable   = ctrl_ff[CTRL_LPC];
  assign lpc_ref_pin  = lpref_ff[LPREF_USEPIN] ?
                        (lpref_ff[LPREF_PINSEL] ? 2'b10 : 2'b01) : 2'b00;
  assign lpc_ref_frac = lpref_ff[LPREF_USEPIN] ? 4'h0 : lpref_ff[3:0];

  generate
    for (genvar a = 0; a < NANA; a++) begin : g_ana
      assign conv_connect[a] = cnf_ff[P_ANA[a]].ana == ANA_CONV;
      assign comp_connect[a] = cnf_ff[P_ANA[a]].ana == ANA_COMP &&
                               ctrl_ff[CTRL_COMP];
      assign lpc_connect[a]  = cnf_ff[P_ANA[a]].ana == ANA_LPC &&
                               ctrl_ff[CTRL_LPC];
    end
  endgenerate

  // ------------------------------------------------------------------
  // Pad drivers
  // ------------------------------------------------------------------
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pad
      always_comb begin
        logic owned;
        logic val;
        logic sel_in;
        logic held;
        owned  = 1'b0;
        val    = 1'b0;
        sel_in = 1'b0;
        held   = 1'b0;
        // lowest function claiming a pin owns it
        for (int f = NOFN - 1; f >= 0; f--) begin
          if (osel_ff[f][SEL_CONN] && osel_ff[f][5:0] == 6'(p)) begin
            owned = 1'b1;
            val   = fn_val[f];
          end
        end
        if (ctrl_ff[CTRL_TRACE]) begin
          if (6'(p) == P_TRC_CLK) begin
            owned = 1'b1;
            val   = trace_clk;
          end
          for (int t = 0; t < 4; t++) begin
            if (6'(p) == P_TRC_D[t]) begin
              owned = 1'b1;
              val   = trace_data[t];
            end
          end
        end
        for (int f = 0; f < NIFN; f++) begin
          sel_in = sel_in | (isel_ff[f][SEL_CONN] &&
                             isel_ff[f][5:0] == 6'(p));
        end
        held = cnf_ff[p].ana != ANA_NONE ||
               (ctrl_ff[CTRL_XTAL] &&
                (6'(p) == P_XTAL_IN || 6'(p) == P_XTAL_OUT)) ||
               (ctrl_ff[CTRL_NFC] &&
                (6'(p) == P_NFC_A || 6'(p) == P_NFC_B));
        if (!owned && cnf_ff[p].dir == DIR_OUT) begin
          val = out_ff[p];
        end
        pad_o[p].ie  = !held && (sel_in || cnf_ff[p].dir != DIR_OFF);
        pad_o[p].oe  = !held && (owned || cnf_ff[p].dir == DIR_OUT) &&
                       !(cnf_ff[p].od && val);
        pad_o[p].out = pad_o[p].oe && val;
        pad_o[p].pu  = !held && cnf_ff[p].pull[1];
        pad_o[p].pd  = !held && cnf_ff[p].pull[0] && !cnf_ff[p].pull[1];
        pad_o[p].hd  = !held && cnf_ff[p].hd;
      end
    end
  endgenerate

  // all routing starts disconnected, see reset values above

endmodule

// ==== core/gfm_pkg.sv ====
package gfm_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NPIN   = 48;
  localparam int NANA   = 10;
  localparam int NPWM   = 16;
  localparam int NAUX   = 8;
  localparam int NOFN   = NPWM + NAUX;
  localparam int NIFN   = 8;
  localparam int NEVT   = 4;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_LPREF   = 12'h004;
  localparam logic [11:0] A_OUT_LO  = 12'h008;
  localparam logic [11:0] A_OUT_HI  = 12'h00C;
  localparam logic [11:0] A_IN_LO   = 12'h010;
  localparam logic [11:0] A_IN_HI   = 12'h014;
  localparam logic [11:0] A_STAT_LO = 12'h018;
  localparam logic [11:0] A_STAT_HI = 12'h01C;
  localparam logic [11:0] A_MASK_LO = 12'h020;
  localparam logic [11:0] A_MASK_HI = 12'h024;
  localparam logic [11:0] A_EVT     = 12'h028;
  localparam logic [11:0] A_CNF     = 12'h100;
  localparam logic [11:0] A_OSEL    = 12'h200;
  localparam logic [11:0] A_ISEL    = 12'h280;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_XTAL  = 0;
  localparam int CTRL_NFC   = 1;
  localparam int CTRL_TRACE = 2;
  localparam int CTRL_COMP  = 3;
  localparam int CTRL_LPC   = 4;
  localparam logic [4:0] CTRL_RST   = 5'h02;
  localparam int LPREF_USEPIN = 4;
  localparam int LPREF_PINSEL = 5;
  localparam logic [5:0] LPREF_RST  = 6'h08;
  localparam int SEL_CONN   = 7;
  localparam int CNF_W      = 10;
  localparam int EVT_ACT    = 8;

  // ------------------------------------------------------------------
  // Fixed pin positions
  // ------------------------------------------------------------------
  localparam logic [5:0] P_XTAL_IN  = 6'h00;
  localparam logic [5:0] P_XTAL_OUT = 6'h01;
  localparam logic [5:0] P_NFC_A    = 6'h02;
  localparam logic [5:0] P_NFC_B    = 6'h03;
  localparam logic [5:0] P_TRC_CLK  = 6'h0C;
  localparam logic [5:0] P_TRC_D [4] = '{6'h0B, 6'h0A, 6'h09, 6'h08};
  localparam logic [5:0] P_ANA [NANA] = '{6'h04, 6'h05, 6'h06, 6'h07,
                                         6'h1A, 6'h1B, 6'h1C, 6'h1D,
                                         6'h1E, 6'h1F};

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {DIR_OFF = 2'h0, DIR_IN = 2'h1,
                            DIR_OUT = 2'h2, DIR_RSV = 2'h3} gfm_dir_t;
  typedef enum logic [1:0] {ANA_NONE = 2'h0, ANA_CONV = 2'h1,
                            ANA_COMP = 2'h2, ANA_LPC = 2'h3} gfm_ana_t;
  typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_SET = 2'h1,
                            ACT_CLR = 2'h2, ACT_TGL = 2'h3} gfm_act_t;

  typedef struct packed {
    gfm_ana_t   ana;
    logic [1:0] sense;  // Bit 0 rising, bit 1 falling
    logic       od;
    logic       hd;
    logic [1:0] pull;   // Bit 0 pull-down, bit 1 pull-up
    gfm_dir_t   dir;
  } gfm_cnf_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic ie;
    logic pu;
    logic pd;
    logic hd;
  } gfm_pad_t;

  // Analog slot of a pin, NANA when not analog-capable
  function automatic logic [3:0] ana_slot(input logic [5:0] p);
    ana_slot = 4'(NANA);
    for (int i = NANA - 1; i >= 0; i--) begin
      if (P_ANA[i] == p) begin
        ana_slot = 4'(i);
      end
    end
  endfunction

endpackage

// ==== dv/gfm_board_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Board pins and peripheral levels
// ------------------------------------------------------------------
module gfm_board_model
  import gfm_pkg::*;
(
  // Pad side
  input  wire gfm_pad_t [NPIN-1:0] pad_o,
  input  wire logic     [NPIN-1:0] ext,
  output logic          [NPIN-1:0] pad_in,
  // Peripheral side
  input  wire logic     [28:0]     pat,
  output logic          [NPWM-1:0] pwm_out,
  output logic          [NAUX-1:0] aux_out,
  output logic                     trace_clk,
  output logic          [3:0]      trace_data
);
  // Wire level: driver, then pulls, then outside source
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_o[i].oe) pad_in[i] = pad_o[i].out;
      else if (pad_o[i].pu) pad_in[i] = 1'b1;
      else if (pad_o[i].pd) pad_in[i] = 1'b0;
      else pad_in[i] = ext[i];
    end
  end

  // Peripheral output levels
  assign {trace_data, trace_clk, aux_out, pwm_out} = pat;
endmodule

// ==== dv/gfm_mux_chk.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------
module gfm_mux_chk
  import gfm_pkg::*;
(
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Bus controls
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  // Pads and events
  input wire gfm_pad_t [NPIN-1:0] pad_o,
  input wire logic     [NPIN-1:0] pin_event,
  // Special and analog
  input wire logic                xtal_connect,
  input wire logic                nfc_connect,
  input wire logic     [NANA-1:0] conv_connect,
  input wire logic     [NANA-1:0] comp_connect,
  input wire logic     [NANA-1:0] lpc_connect,
  input wire logic                comp_enable,
  input wire logic                lpc_enable,
  input wire logic     [1:0]      lpc_ref_pin,
  input wire logic     [3:0]      lpc_ref_frac,
  // Interrupt
  input wire logic                irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Comparators never both on
  property p_cmp_one;
    !(comp_enable && lpc_enable);
  endproperty
  a_cmp_one: assert property (p_cmp_one)
    else $error("both comparators on");

  // One analog function per slot
  property p_ana_one;
    ((conv_connect & comp_connect) | (conv_connect & lpc_connect) |
     (comp_connect & lpc_connect)) == '0;
  endproperty
  a_ana_one: assert property (p_ana_one)
    else $error("analog slot shared");

  // Negative input is one pin or a nonzero fraction
  property p_ref;
    lpc_ref_pin != 2'h3 &&
    ((lpc_ref_pin != 2'h0) ? lpc_ref_frac == 4'h0 : lpc_ref_frac != 4'h0);
  endproperty
  a_ref: assert property (p_ref)
    else $error("bad low power reference");

  // Crystal pins leave the pad logic
  property p_xtal;
    xtal_connect |-> pad_o[0] == '0 && pad_o[1] == '0;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal pin still driven");

  // Antenna pins leave the pad logic
  property p_nfc;
    nfc_connect |-> pad_o[2] == '0 && pad_o[3] == '0;
  endproperty
  a_nfc: assert property (p_nfc)
    else $error("antenna pin still driven");

  // Connections at reset release
  property p_rst;
    $rose(presetn) |-> nfc_connect && !xtal_connect && !comp_enable &&
      !lpc_enable && lpc_ref_frac == 4'h8 && !irq;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad state after reset");

  // All pads disabled at reset release
  property p_off;
    $rose(presetn) |-> pad_o == '0 && (conv_connect | lpc_connect) == '0;
  endproperty
  a_off: assert property (p_off)
    else $error("pad not disabled after reset");

  // Interrupt rises only on an edge or a write
  property p_irq;
    $rose(irq) |-> (|pin_event) || $past(psel && penable && pwrite);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without cause");

  c_irq: cover property ($rose(irq));
  c_lpc: cover property (lpc_enable);
  c_xtal: cover property (xtal_connect);
endmodule

bind gfm_mux gfm_mux_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pad_o, .pin_event,
  .xtal_connect, .nfc_connect, .conv_connect, .comp_connect,
  .lpc_connect, .comp_enable, .lpc_enable, .lpc_ref_pin, .lpc_ref_frac,
  .irq
);

// ==== dv/gfm_mux_test.sv ====
`timescale 1ns/1ps
module gfm_mux_test;
  import gfm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 pclk, presetn, psel, penable, pwrite, pready;
  logic                 pslverr, trace_clk, xtal_connect, nfc_connect;
  logic                 comp_enable, lpc_enable, irq, er;
  logic      [11:0]     paddr;
  logic      [31:0]     pwdata, prdata, rd;
  logic      [NPIN-1:0] pad_in, pin_event, ext;
  gfm_pad_t  [NPIN-1:0] pad_o;
  logic      [NPWM-1:0] pwm_out;
  logic      [NAUX-1:0] aux_out;
  logic      [NIFN-1:0] periph_in;
  logic      [3:0]      trace_data, evt_task, lpc_ref_frac;
  logic      [NANA-1:0] conv_connect, comp_connect, lpc_connect;
  logic      [1:0]      lpc_ref_pin;
  logic      [28:0]     pat;
  int                   mismatches, n_compared, n;

  gfm_mux dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pad_in, .pad_o, .pwm_out, .aux_out,
    .periph_in, .trace_clk, .trace_data, .evt_task, .pin_event,
    .xtal_connect, .nfc_connect, .conv_connect, .comp_connect,
    .lpc_connect, .comp_enable, .lpc_enable, .lpc_ref_pin, .lpc_ref_frac,
    .irq);
  gfm_board_model board (.pad_o, .ext, .pad_in, .pat, .pwm_out, .aux_out,
    .trace_clk, .trace_data);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic bchk(input logic g, input logic e, input string m);
    chk({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic pchk(input int p, input logic [5:0] e, input string m);
    chk({26'h0, pad_o[p]}, {26'h0, e}, m);
  endtask
  // One bus transfer, released after pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] msk,
                     input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd & msk, e, m);
  endtask
  function automatic logic [11:0] cnf(input int p);
    return A_CNF + 12'(4 * p);
  endfunction
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {evt_task, ext, pat, mismatches, n_compared} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_CTRL, 32'h1F, 32'h02, "ctrl");
    rdc(A_LPREF, 32'h3F, 32'h08, "lpref");
    pchk(20, 6'h00, "off");
    bchk(nfc_connect, 1'b1, "nfc");
    xfer(1'b0, 12'h300, 32'h0);
    bchk(er, 1'b1, "err");
    chk(rd, 32'h0, "errdata");
    // Output drive kinds
    wr(cnf(20), 32'h2);
    wr(A_OUT_LO, 32'h0010_0000);
    pchk(20, 6'h38, "pp");
    wr(cnf(20), 32'h32);
    pchk(20, 6'h09, "od1");
    wr(A_OUT_LO, 32'h0);
    pchk(20, 6'h19, "od0");
    wr(cnf(20), 32'h2);
    // Event channel set, clear, toggle
    for (int a = 1; a < 4; a++) begin
      wr(A_EVT, 32'(a << EVT_ACT) | 32'd20);
      evt_task <= 4'h1;
      @(posedge pclk);
      evt_task <= 4'h0;
      @(posedge pclk);
      bchk(pad_o[20].out, a != 2, "evt");
    end
    // Input pulls
    wr(cnf(21), 32'h9);
    pchk(21, 6'h0C, "pu");
    repeat (2) @(posedge pclk);
    rdc(A_IN_LO, 32'h0020_0000, 32'h0020_0000, "inpu");
    wr(cnf(21), 32'h5);
    pchk(21, 6'h0A, "pd");
    repeat (2) @(posedge pclk);
    rdc(A_IN_LO, 32'h0020_0000, 32'h0, "inpd");
    // Rising edge with interrupt, then masked
    wr(cnf(21), 32'h41);
    wr(A_MASK_LO, 32'h0020_0000);
    ext <= 48'h0000_0020_0000;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pin_event[21] !== 1'b1 && n < 10);
    bchk(pin_event[21], 1'b1, "pev");
    bchk(irq, 1'b1, "irq");
    @(posedge pclk);
    rdc(A_STAT_LO, 32'h0020_0000, 32'h0020_0000, "stat");
    wr(A_STAT_LO, 32'h0020_0000);
    bchk(irq, 1'b0, "clr");
    wr(A_ISEL, 32'h95);
    repeat (3) @(posedge pclk);
    bchk(periph_in[0], 1'b1, "isel");
    ext <= '0;
    wr(A_MASK_LO, 32'h0);
    ext <= 48'h0000_0020_0000;
    repeat (6) @(posedge pclk);
    bchk(irq, 1'b0, "mask");
    rdc(A_STAT_LO, 32'h0020_0000, 32'h0020_0000, "stat2");
    // Modulator routing and occupied pin
    wr(A_OSEL + 12'h00C, 32'h96);
    pat <= 29'h8;
    @(posedge pclk);
    bchk(pad_o[22].out & pad_o[22].oe, 1'b1, "pwm");
    pchk(23, 6'h00, "unrouted");
    wr(A_OSEL + 12'h014, 32'h96);
    pat <= 29'h20;
    @(posedge pclk);
    bchk(pad_o[22].out, 1'b0, "owner");
    // Trace pins
    wr(A_CTRL, 32'h06);
    pat <= {4'h5, 1'b1, 24'h0};
    @(posedge pclk);
    bchk(pad_o[P_TRC_CLK].out, 1'b1, "tclk");
    for (int i = 0; i < 4; i++) begin
      bchk(pad_o[P_TRC_D[i]].out, i % 2 == 0, "tdat");
    end
    // Analog sharing
    wr(cnf(20), 32'h102);
    rdc(cnf(20), 32'h300, 32'h0, "ana");
    wr(cnf(4), 32'h100);
    chk({22'h0, conv_connect}, 32'h1, "conv");
    wr(A_CTRL, 32'h1A);
    rdc(A_CTRL, 32'h18, 32'h08, "cmp");
    wr(A_CTRL, 32'h12);
    wr(cnf(5), 32'h300);
    bchk(lpc_connect[1], 1'b1, "lpc");
    wr(A_LPREF, 32'h30);
    chk({26'h0, lpc_ref_pin, lpc_ref_frac}, 32'h20, "refpin");
    wr(A_LPREF, 32'h0);
    rdc(A_LPREF, 32'h3F, 32'h30, "refz");
    wr(A_LPREF, 32'h0F);
    chk({26'h0, lpc_ref_pin, lpc_ref_frac}, 32'h0F, "frac");
    // Crystal pins
    wr(A_CTRL, 32'h01);
    bchk(xtal_connect, 1'b1, "xtal");
    bchk(nfc_connect, 1'b0, "nfcoff");
    wr(cnf(0), 32'h2);
    pchk(0, 6'h00, "xpad");
    // Reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_CTRL, 32'h1F, 32'h02, "rst");
    pchk(20, 6'h00, "rstpad");
    report_and_stop();
  end
endmodule
